// file: logic/fps_defs.svh
/*
 flash programmer status and power-state constants.
 assumes a 200 MHz clk; included by bare name from logic files.
*/
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

`define FPS_CLK_MHZ 200
`define FPS_SETUP_MS 10
`define FPS_SETUP_CYC (`FPS_SETUP_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_OSC_XTAL_MS 10
`define FPS_OSC_CERA_MS 5
`define FPS_OSC_XTAL_CYC (`FPS_OSC_XTAL_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_OSC_CERA_CYC (`FPS_OSC_CERA_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_WAKE_US 20
`define FPS_WAKE_CYC (`FPS_WAKE_US * `FPS_CLK_MHZ)

`define FPS_ADDR_CTRL 4'h0
`define FPS_ADDR_STAT 4'h1
`define FPS_ADDR_IRQS 4'h2
`define FPS_ADDR_IMSK 4'h3
`define FPS_ADDR_WAIT 4'h4

`define FPS_BIT_PROGRESS 7
`define FPS_BIT_OUTCOME 6
`define FPS_LOW_W 6

`define FPS_IRQ_READY 0
`define FPS_IRQ_DONE 1
`define FPS_IRQ_FAIL 2
`define FPS_IRQ_WAKE 3
`define FPS_IRQ_IGNORED 4
`define FPS_IRQ_W 5

`define FPS_WAIT_SEL_RESET 3'h0
`define FPS_WAIT_STEP_CYC 16'h0FA0
`endif

// file: logic/fps_pkg.sv
/*
 types shared by the flash status/power block.
 assumes nothing beyond the defs header.
*/
package fps_pkg;
	typedef enum logic [1:0] {FPS_FL_NORMAL, FPS_FL_POWERDOWN, FPS_FL_STANDBY} fps_flash_e;
	typedef enum logic [2:0] {FPS_CM_ACTIVE, FPS_CM_SUBACTIVE, FPS_CM_SLEEP, FPS_CM_SUBSLEEP,
		FPS_CM_STANDBY, FPS_CM_WATCH} fps_chip_e;
	typedef enum logic [1:0] {FPS_PM_OSC, FPS_PM_SETUP, FPS_PM_READ, FPS_PM_BUSY} fps_prog_e;
endpackage

// file: logic/fps_wake_if.sv
/*
 interface between the power selector and its wake-wait timer.
 assumes one clk domain.
*/
`timescale 1ns/1ps
interface fps_wake_if;
	logic start;
	logic [2:0] waitSel;
	logic busy;
	logic done;
	modport ctl (output start, output waitSel, input busy, input done);
	modport tmr (input start, input waitSel, output busy, output done);
endinterface

// file: logic/fps_wake_timer.sv
/*
 wake-up stabilisation wait counter for the flash power circuits.
 assumes start is a one-cycle pulse from the same clk.
*/
`timescale 1ns/1ps
`include "fps_defs.svh"
module fps_wake_timer (
	input wire logic clk,
	input wire logic rst,
	fps_wake_if.tmr wk
);
	logic [18:0] count;
	logic busy;
	logic done;
	wire [18:0] loadVal = 19'(`FPS_WAKE_CYC) + 19'(wk.waitSel) * 19'(`FPS_WAIT_STEP_CYC);

	assign wk.busy = busy;
	assign wk.done = done;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count <= 19'h0_0000;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (wk.start)
			begin
				// never shorter than the 20 us floor, whatever the select says
				count <= loadVal;
				busy <= 1'b1;
			end
			else if (busy)
			begin
				count <= count - 19'h0_0001;
				if (count == 19'h0_0001)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// file: logic/fps_core.sv
/*
 flash programmer-mode status polling, entry timing and user-mode power state.
 assumes programmer pins come from outside clk (synchronised here), and
 a register master on clk following the plain strobe protocol.
*/
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fps_defs.svh"
// Operation
// [RULE1] bit 7 low while busy, high when done
// [RULE2] bit 6 gives outcome, bits 0-5 low
// [RULE3] never bit 7 low with bit 6 high
// [RULE4] status held until next command write
// [RULE5] commands ignored during stabilisation and setup
// [RULE6] programmer waits 10 ms crystal, 5 ms ceramic
// [RULE7] 10 ms setup before commands accepted
// [RULE8] after setup enter memory read mode
// [RULE9] programmer erases before reprogramming
// [RULE10] erase chips of unknown history first
// [RULE11] flash is normal, power-down or standby
// [RULE12] subactive: bit 0 power-down, 1 normal
// [RULE13] active/sleep normal; sub-sleep/standby/watch standby
// [RULE14] software sets wait of at least 20 us
module fps_core #(
	parameter int SETUP_CYC = `FPS_SETUP_CYC,
	parameter int OSC_CYC = `FPS_OSC_XTAL_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic progModePin,
	input wire logic cmdWritePin,
	input wire logic opEndPin,
	input wire logic opFailPin,
	input wire logic readEnablePin,
	input wire logic [2:0] chipMode,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata,
	output logic [7:0] statusData,
	output logic statusOe,
	output logic cmdAccept,
	output logic [1:0] flashState,
	output logic flashReady,
	output logic irq
);
	logic [1:0] syncMode, syncCmd, syncEnd, syncFail, syncRe;
	logic cmdPrev, endPrev;
	fps_pkg::fps_prog_e progState;
	logic [31:0] progCount;
	logic progressFlag;
	logic outcomeFlag;
	logic flashLowPowerDisable;
	logic [2:0] standbyWaitSelect;
	logic [`FPS_IRQ_W-1:0] irqStatus;
	logic [`FPS_IRQ_W-1:0] irqMask;
	fps_pkg::fps_flash_e flashMode;
	fps_pkg::fps_flash_e prevFlashMode;

	fps_wake_if wk();

	fps_wake_timer u_wake (
		.clk(clk),
		.rst(rst),
		.wk(wk)
	);

	// two-stage synchronisers for every programmer pin
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			syncMode <= 2'h0;
			syncCmd <= 2'h0;
			syncEnd <= 2'h0;
			syncFail <= 2'h0;
			syncRe <= 2'h0;
		end
		else
		begin
			syncMode <= {syncMode[0], progModePin};
			syncCmd <= {syncCmd[0], cmdWritePin};
			syncEnd <= {syncEnd[0], opEndPin};
			syncFail <= {syncFail[0], opFailPin};
			syncRe <= {syncRe[0], readEnablePin};
		end
	end

	wire progMode = syncMode[1];
	wire cmdLevel = syncCmd[1];
	wire endLevel = syncEnd[1];
	wire cmdRise = cmdLevel && !cmdPrev;
	wire endRise = endLevel && !endPrev;
	wire inWaitPhase = (progState == fps_pkg::FPS_PM_OSC) || (progState == fps_pkg::FPS_PM_SETUP);
	wire cmdTaken = cmdRise && !inWaitPhase && progMode; // [RULE5]
	wire cmdDropped = cmdRise && inWaitPhase && progMode; // [RULE5]
	wire oscDone = progCount >= 32'(OSC_CYC - 1); // [RULE6]
	wire setupDone = progCount >= 32'(SETUP_CYC - 1); // [RULE7]

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cmdPrev <= 1'b0;
			endPrev <= 1'b0;
		end
		else
		begin
			cmdPrev <= cmdLevel;
			endPrev <= endLevel;
		end
	end

	// programmer-mode entry sequence and operation tracking
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			progState <= fps_pkg::FPS_PM_OSC;
			progCount <= 32'h0000_0000;
		end
		else if (!progMode)
		begin
			progState <= fps_pkg::FPS_PM_OSC;
			progCount <= 32'h0000_0000;
		end
		else
		begin
			case (progState)
				fps_pkg::FPS_PM_OSC:
				begin
					progCount <= oscDone ? 32'h0000_0000 : progCount + 32'h0000_0001;
					if (oscDone)
						progState <= fps_pkg::FPS_PM_SETUP;
				end
				fps_pkg::FPS_PM_SETUP:
				begin
					progCount <= progCount + 32'h0000_0001;
					if (setupDone)
						progState <= fps_pkg::FPS_PM_READ; // [RULE8]
				end
				fps_pkg::FPS_PM_READ:
				begin
					if (cmdTaken)
						progState <= fps_pkg::FPS_PM_BUSY;
				end
				fps_pkg::FPS_PM_BUSY:
				begin
					if (endRise)
						progState <= fps_pkg::FPS_PM_READ;
				end
				default:
					progState <= fps_pkg::FPS_PM_OSC;
			endcase
		end
	end

	// polling flags: busy clears both, end sets progress and latches outcome
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			progressFlag <= 1'b1;
			outcomeFlag <= 1'b0;
		end
		else if (cmdTaken)
		begin
			progressFlag <= 1'b0; // [RULE1]
			outcomeFlag <= 1'b0; // [RULE3]
		end
		else if (progState == fps_pkg::FPS_PM_BUSY && endRise)
		begin
			progressFlag <= 1'b1; // [RULE1]
			outcomeFlag <= !syncFail[1]; // [RULE2]
		end
	end

	// flags only ever change on a taken command or an end, so they hold between
	assign statusData = {progressFlag, outcomeFlag && progressFlag, `FPS_LOW_W'(0)}; // [RULE2] [RULE3] [RULE4]
	assign statusOe = syncRe[1] && progMode; // [RULE4]
	assign cmdAccept = progMode && !inWaitPhase;

	// user-mode flash power state
	function automatic fps_pkg::fps_flash_e selectFlash(input logic [2:0] mode, input logic lpDisable);
		case (mode)
			fps_pkg::FPS_CM_ACTIVE,
			fps_pkg::FPS_CM_SLEEP:
				selectFlash = fps_pkg::FPS_FL_NORMAL; // [RULE13]
			fps_pkg::FPS_CM_SUBACTIVE:
				selectFlash = lpDisable ? fps_pkg::FPS_FL_NORMAL : fps_pkg::FPS_FL_POWERDOWN; // [RULE12]
			default:
				selectFlash = fps_pkg::FPS_FL_STANDBY; // [RULE13]
		endcase
	endfunction

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flashMode <= fps_pkg::FPS_FL_NORMAL;
			prevFlashMode <= fps_pkg::FPS_FL_NORMAL;
		end
		else
		begin
			flashMode <= selectFlash(chipMode, flashLowPowerDisable); // [RULE11]
			prevFlashMode <= flashMode;
		end
	end

	wire wakeEvent = (flashMode == fps_pkg::FPS_FL_NORMAL) && (prevFlashMode != fps_pkg::FPS_FL_NORMAL);
	assign wk.start = wakeEvent;
	assign wk.waitSel = standbyWaitSelect; // [RULE14]
	assign flashState = flashMode;
	// reads are held off until the stopped supply circuits have settled
	assign flashReady = (flashMode != fps_pkg::FPS_FL_STANDBY) && !wk.busy && !wakeEvent;

	// register port and interrupt status
	wire wrCtrl = regWrite && regAddr == `FPS_ADDR_CTRL;
	wire wrIrqs = regWrite && regAddr == `FPS_ADDR_IRQS;
	wire wrImsk = regWrite && regAddr == `FPS_ADDR_IMSK;
	wire wrWait = regWrite && regAddr == `FPS_ADDR_WAIT;
	wire [`FPS_IRQ_W-1:0] irqEvents;
	assign irqEvents[`FPS_IRQ_READY] = (progState == fps_pkg::FPS_PM_SETUP) && setupDone && progMode;
	assign irqEvents[`FPS_IRQ_DONE] = (progState == fps_pkg::FPS_PM_BUSY) && endRise && !syncFail[1];
	assign irqEvents[`FPS_IRQ_FAIL] = (progState == fps_pkg::FPS_PM_BUSY) && endRise && syncFail[1];
	assign irqEvents[`FPS_IRQ_WAKE] = wk.done;
	assign irqEvents[`FPS_IRQ_IGNORED] = cmdDropped;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flashLowPowerDisable <= 1'b0; // [RULE12]
			standbyWaitSelect <= `FPS_WAIT_SEL_RESET;
			irqMask <= '0;
			irqStatus <= '0;
		end
		else
		begin
			if (wrCtrl)
				flashLowPowerDisable <= regWdata[0];
			if (wrWait)
				standbyWaitSelect <= regWdata[2:0];
			if (wrImsk)
				irqMask <= regWdata[`FPS_IRQ_W-1:0];
			// a new event wins over a write-one clear in the same cycle
			irqStatus <= (irqStatus & ~(wrIrqs ? regWdata[`FPS_IRQ_W-1:0] : '0)) | irqEvents;
		end
	end

	assign irq = |(irqStatus & irqMask);

	logic [7:0] readMux;
	always_comb
	begin
		case (regAddr)
			`FPS_ADDR_CTRL: readMux = {7'h00, flashLowPowerDisable};
			`FPS_ADDR_STAT: readMux = {flashReady, wk.busy, cmdAccept, progressFlag, flashMode, progState};
			`FPS_ADDR_IRQS: readMux = {3'h0, irqStatus};
			`FPS_ADDR_IMSK: readMux = {3'h0, irqMask};
			`FPS_ADDR_WAIT: readMux = {5'h00, standbyWaitSelect};
			default: readMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			regRdata <= 8'h00;
		else
			regRdata <= regRead ? readMux : 8'h00;
	end
endmodule

// file: sim/fps_sva.sv
/*
 concurrent checks on the flash status/power block.
 assumes the single clk domain and async rst of fps_core.
*/
`timescale 1ns/1ps
module fps_sva (
	input wire logic clk,
	input wire logic rst,
	input wire logic progModePin,
	input wire logic [2:0] chipMode,
	input wire logic [7:0] statusData,
	input wire logic cmdAccept,
	input wire logic [1:0] flashState,
	input wire logic flashReady
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence wakeStart;
		flashState == 2'h0 && $past(flashState) != 2'h0;
	endsequence
	sequence heldOff;
		!flashReady [*8];
	endsequence
	chk_low_bits_zero: assert property (statusData[5:0] == 6'h00) else $error("low status bits set");
	chk_no_bad_combo: assert property (statusData[7] || !statusData[6]) else $error("undefined status pair");
	chk_state_normal: assert property (chipMode == 3'h0 || chipMode == 3'h2 |=> flashState == 2'h0)
		else $error("not normal in active or sleep");
	chk_state_standby: assert property (chipMode >= 3'h3 |=> flashState == 2'h2)
		else $error("not standby in low modes");
	chk_pd_source: assert property (flashState == 2'h1 |-> $past(chipMode) == 3'h1)
		else $error("power-down outside subactive");
	chk_accept_late: assert property ($rose(cmdAccept) |-> progModePin && $past(progModePin, 90))
		else $error("commands accepted too early");
	chk_ready_standby: assert property (flashState == 2'h2 && $past(flashState) == 2'h2 |-> !flashReady)
		else $error("ready while in standby");
	chk_wake_wait: assert property (wakeStart |-> ##3 heldOff) else $error("no wake wait");
endmodule
bind fps_core fps_sva chk (.clk(clk), .rst(rst), .progModePin(progModePin), .chipMode(chipMode),
	.statusData(statusData), .cmdAccept(cmdAccept), .flashState(flashState), .flashReady(flashReady));

// file: sim/fps_prog_model.sv
/*
 external parallel programmer driving the programmer-mode pins.
 assumes the bench calls its tasks; pins change just after clk edges.
*/
`timescale 1ns/1ps
module fps_prog_model #(
	parameter int WAIT_CYC = 100
) (
	input wire logic clk,
	output logic progModePin,
	output logic cmdWritePin,
	output logic opEndPin,
	output logic opFailPin,
	output logic readEnablePin
);
	initial
	begin
		progModePin = 0;
		cmdWritePin = 0;
		opEndPin = 0;
		opFailPin = 0;
		readEnablePin = 0;
	end
	task enter();
		@(posedge clk);
		progModePin <= 1;
		readEnablePin <= 1;
	endtask
	// a polite programmer sits out oscillation and setup before any command
	task settle();
		repeat (WAIT_CYC) @(posedge clk);
	endtask
	// erase-first ordering is up to the caller's command sequence
	task cmd();
		@(posedge clk);
		cmdWritePin <= 1;
		repeat (2) @(posedge clk);
		cmdWritePin <= 0;
	endtask
	task finish(input logic fail);
		@(posedge clk);
		opFailPin <= fail;
		@(posedge clk);
		opEndPin <= 1;
		repeat (4) @(posedge clk);
		opEndPin <= 0;
	endtask
endmodule

// file: sim/flash_programmer_status_power_tb.sv
/*
 self-checking bench for fps_core with a programmer model.
 assumes short osc and setup counts of 50 cycles each.
*/
`timescale 1ns/1ps
`include "fps_defs.svh"
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module flash_programmer_status_power_tb;
	logic clk = 0, rst = 1, regWrite = 0, regRead = 0;
	logic [2:0] chipMode = 3'h0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, regRdata, statusData, v;
	logic progModePin, cmdWritePin, opEndPin, opFailPin, readEnablePin, statusOe, cmdAccept, flashReady, irq, f;
	logic [1:0] flashState;
	logic [31:0] seed = 32'he15e_fcf9, r;
	int fails = 0, checkCount = 0, n;
	always #2.5 clk = ~clk;
	// settle is called some 30 cycles into the entry, so 110 more covers osc, setup and the synchronisers
	fps_prog_model #(.WAIT_CYC(110)) prog (.clk(clk), .progModePin(progModePin), .cmdWritePin(cmdWritePin),
		.opEndPin(opEndPin),
		.opFailPin(opFailPin), .readEnablePin(readEnablePin));
	fps_core #(.SETUP_CYC(50), .OSC_CYC(50)) dut (.clk(clk), .rst(rst), .progModePin(progModePin),
		.cmdWritePin(cmdWritePin), .opEndPin(opEndPin), .opFailPin(opFailPin), .readEnablePin(readEnablePin),
		.chipMode(chipMode), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .statusData(statusData), .statusOe(statusOe), .cmdAccept(cmdAccept),
		.flashState(flashState), .flashReady(flashReady), .irq(irq));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [1:0] expState(input logic [2:0] m, input logic p);
		if (m == 3'h0 || m == 3'h2 || (m == 3'h1 && p))
			return fps_pkg::FPS_FL_NORMAL;
		return (m == 3'h1) ? fps_pkg::FPS_FL_POWERDOWN : fps_pkg::FPS_FL_STANDBY;
	endfunction
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1;
		@(posedge clk);
		regWrite <= 0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1;
		@(posedge clk);
		regRead <= 0;
		#1 d = regRdata;
	endtask
	task giveVerdict();
		if (fails == 0 && checkCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#200000;
		fails++;
		giveVerdict();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 0;
		rd(4'hF, v);
		`CHK(v, 8'h00)
		rd(`FPS_ADDR_CTRL, v);
		`CHK(v, 8'h00)
		for (int i = 0; i < 32; i++)
		begin
			r = (i < 16) ? i : xs();
			wr(`FPS_ADDR_CTRL, {7'h00, r[0]});
			chipMode <= r[3:1];
			repeat (3) @(posedge clk);
			`CHK(flashState, expState(r[3:1], r[0]))
		end
		rd(`FPS_ADDR_CTRL, v);
		`CHK(v, {7'h00, r[0]})
		// each wait select step stretches the wake wait by one more floor length
		for (int s = 0; s < 2; s++)
		begin
			@(posedge clk);
			chipMode <= 3'h4;
			wr(`FPS_ADDR_IMSK, 8'h00);
			#1 `CHK(irq, 1'b0)
			wr(`FPS_ADDR_IRQS, 8'hFF);
			wr(`FPS_ADDR_IMSK, 8'h08);
			wr(`FPS_ADDR_WAIT, 8'(s));
			chipMode <= 3'h0;
			repeat (4) @(posedge clk);
			`CHK(flashReady, 1'b0)
			n = 0;
			while (!irq && n < 4200 + s * `FPS_WAIT_STEP_CYC)
			begin
				@(posedge clk);
				n++;
			end
			`CHK(irq, 1'b1)
			`CHK(n > 3990 + s * `FPS_WAIT_STEP_CYC, 1'b1)
			`CHK(flashReady, 1'b1)
			wr(`FPS_ADDR_IRQS, 8'h08);
			#1 `CHK(irq, 1'b0)
		end
		prog.enter();
		repeat (20) @(posedge clk);
		prog.cmd();
		repeat (8) @(posedge clk);
		`CHK(statusData, 8'h80)
		`CHK(cmdAccept, 1'b0)
		rd(`FPS_ADDR_IRQS, v);
		`CHK(v[`FPS_IRQ_IGNORED], 1'b1)
		prog.settle();
		`CHK(cmdAccept, 1'b1)
		rd(`FPS_ADDR_STAT, v);
		`CHK(v, 8'hB2)
		for (int k = 0; k < 6; k++)
		begin
			r = xs();
			f = (k < 2) ? k[0] : r[0];
			prog.cmd();
			repeat (8) @(posedge clk);
			`CHK(statusData, 8'h00)
			prog.finish(f);
			repeat (8) @(posedge clk);
			`CHK(statusData, f ? 8'h80 : 8'hC0)
			repeat (20) @(posedge clk);
			`CHK(statusData, f ? 8'h80 : 8'hC0)
			`CHK(statusOe, 1'b1)
		end
		// ready, normal end, abnormal end and the ignored command, but no stray wake
		rd(`FPS_ADDR_IRQS, v);
		`CHK(v, 8'h17)
		giveVerdict();
	end
endmodule
